// *** verilog/frsd_defines.svh ***
`ifndef FRSD_DEFINES_SVH
`define FRSD_DEFINES_SVH

// Register indices; byte address is four times the index
`define FRSD_IDX_FMT        14'h0138
`define FRSD_IDX_SRC        14'h0139
`define FRSD_IDX_DIV_HI     14'h013a
`define FRSD_IDX_DIV_LO     14'h013b
`define FRSD_IDX_DLY_HI     14'h013c
`define FRSD_IDX_DLY_LO     14'h013d
`define FRSD_IDX_BURST      14'h013e
`define FRSD_IDX_PD         14'h0140
`define FRSD_IDX_STATUS     14'h0141

// Reset values
`define FRSD_RST_FMT        8'h04
`define FRSD_RST_SRC        8'h00
`define FRSD_RST_DIV_HI     8'h0c
`define FRSD_RST_DIV_LO     8'h00
`define FRSD_RST_DLY_HI     8'h00
`define FRSD_RST_DLY_LO     8'h08
`define FRSD_RST_BURST      8'h03
`define FRSD_RST_PD         8'h05

// Writable bit masks, reserved bits read zero
`define FRSD_MSK_FMT        8'h6f
`define FRSD_MSK_SRC        8'h07
`define FRSD_MSK_HI         8'h1f
`define FRSD_MSK_LO         8'hff
`define FRSD_MSK_BURST      8'h03
`define FRSD_MSK_PD         8'h05

// Field positions
`define FRSD_FMT_DIST_HI    6
`define FRSD_FMT_DIST_LO    5
`define FRSD_FMT_OUT_HI     3
`define FRSD_FMT_OUT_LO     0
`define FRSD_SRC_BYPASS     2
`define FRSD_PD_FRAME       2
`define FRSD_PD_PULSER      0

// Field codes
`define FRSD_DIST_FIRST     2'h0
`define FRSD_DIST_SECOND    2'h1
`define FRSD_OUT_OFF        4'h0
`define FRSD_OUT_LVDS       4'h1
`define FRSD_OUT_PECL_LO    4'h4
`define FRSD_OUT_PECL_HI    4'h5
`define FRSD_OUT_CMOS_FIRST 4'h6
`define FRSD_OUT_CMOS_LAST  4'he

// Least legal divide and delay value
`define FRSD_MIN_COUNT      13'h0008

`endif

// *** verilog/frsd_pkg.sv ***
`include "frsd_defines.svh"

package frsd_pkg;

  typedef enum logic [1:0] {
    FRSD_SRC_NORMAL,
    FRSD_SRC_RECLOCK,
    FRSD_SRC_PULSER,
    FRSD_SRC_CONT
  } frsd_src_t;

  // Per-pin LVCMOS setting
  typedef enum logic [1:0] {
    FRSD_PIN_OFF,
    FRSD_PIN_NORM,
    FRSD_PIN_INV
  } frsd_pin_t;

  // Out-of-range counts are lifted to the least legal value
  function automatic logic [12:0] frsd_sat(input logic [12:0] v);
    frsd_sat = (v < `FRSD_MIN_COUNT) ? `FRSD_MIN_COUNT : v;
  endfunction : frsd_sat

endpackage : frsd_pkg

// *** verilog/frsd_divider.sv ***
`timescale 1ns/1ps
`include "frsd_defines.svh"

// Frame-reference divider with leading digital delay
module frsd_divider #(
  parameter int W = 13
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] delay,
  output logic              clk_out,
  output logic              rise,
  output logic              fall
);

  logic         in_delay;
  logic [W-1:0] delay_cnt;
  logic [W-1:0] cnt;

  wire  [W-1:0] half       = W'(({1'b0, period} + (W+1)'(1)) >> 1);
  wire          delay_done = (delay_cnt == W'(delay - W'(1)));
  wire          wrap       = (cnt == W'(period - W'(1)));
  wire  [W-1:0] next_cnt   = in_delay ? '0 : (wrap ? '0 : W'(cnt + W'(1)));
  wire          next_hi    = (in_delay && !delay_done) ? 1'b0 : (next_cnt < half);

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      in_delay  <= 1'b1;
      delay_cnt <= '0;
      cnt       <= '0;
      clk_out   <= 1'b0;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      if (in_delay) begin
        delay_cnt <= W'(delay_cnt + W'(1));
        in_delay  <= !delay_done;
      end
      cnt     <= next_cnt;
      clk_out <= next_hi;
      rise    <= next_hi && !clk_out;
      fall    <= !next_hi && clk_out;
    end
  end

endmodule : frsd_divider

// *** verilog/frsd_regbank.sv ***
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "frsd_defines.svh"

module frsd_regbank (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [15:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        OSC_REF_IN,
  input  wire logic        FIRST_REF_IN,
  input  wire logic        SYNC_IN,
  output logic             DIST_FIRST_OSC,
  output logic             DIST_SECOND_OSC,
  output logic             BUF_OUT_LVDS,
  output logic             BUF_OUT_LVPECL,
  output logic             BUF_OUT_SWING_HIGH,
  output logic             THIRD_REF_IN_EN,
  output logic             BUF_CMOS_A_O,
  output logic             BUF_CMOS_A_OE,
  output logic             BUF_CMOS_B_O,
  output logic             BUF_CMOS_B_OE,
  output logic             FRAME_REF_OUT
);

  // Registers
  logic [7:0] fmt_reg;
  logic [7:0] src_reg;
  logic [7:0] div_hi;
  logic [7:0] div_lo;
  logic [7:0] dly_hi;
  logic [7:0] dly_lo;
  logic [7:0] burst_reg;
  logic [7:0] pd_reg;

  // Pin synchronisers
  logic [1:0] osc_sync;
  logic [1:0] first_sync;
  logic [1:0] sync_sync;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      osc_sync   <= 2'h0;
      first_sync <= 2'h0;
      sync_sync  <= 2'h0;
    end else begin
      osc_sync   <= {osc_sync[0], OSC_REF_IN};
      first_sync <= {first_sync[0], FIRST_REF_IN};
      sync_sync  <= {sync_sync[0], SYNC_IN};
    end
  end

  wire osc_s   = osc_sync[1];
  wire first_s = first_sync[1];
  wire sync_s  = sync_sync[1];

  // Bus decode
  wire        bus_req  = WB_CYC_I && WB_STB_I;
  wire [13:0] word_idx = WB_ADR_I[15:2];
  wire        wr_take  = bus_req && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  wire        ack_next = bus_req && !WB_ACK_O;

  wire hit_fmt    = (word_idx == `FRSD_IDX_FMT);
  wire hit_src    = (word_idx == `FRSD_IDX_SRC);
  wire hit_div_hi = (word_idx == `FRSD_IDX_DIV_HI);
  wire hit_div_lo = (word_idx == `FRSD_IDX_DIV_LO);
  wire hit_dly_hi = (word_idx == `FRSD_IDX_DLY_HI);
  wire hit_dly_lo = (word_idx == `FRSD_IDX_DLY_LO);
  wire hit_burst  = (word_idx == `FRSD_IDX_BURST);
  wire hit_pd     = (word_idx == `FRSD_IDX_PD);
  wire hit_status = (word_idx == `FRSD_IDX_STATUS);

  wire [7:0] wdat = WB_DAT_I[7:0];

  // Field decode
  wire [1:0]  dist_code   = fmt_reg[`FRSD_FMT_DIST_HI:`FRSD_FMT_DIST_LO];
  wire [3:0]  out_code    = fmt_reg[`FRSD_FMT_OUT_HI:`FRSD_FMT_OUT_LO];
  wire        bypass      = src_reg[`FRSD_SRC_BYPASS];
  wire        frame_pd    = pd_reg[`FRSD_PD_FRAME];
  wire        pulser_pd   = pd_reg[`FRSD_PD_PULSER];
  wire [12:0] div_value   = {div_hi[4:0], div_lo};
  wire [12:0] dly_value   = {dly_hi[4:0], dly_lo};
  // Reserved counts below eight run as eight
  wire [12:0] div_eff     = frsd_pkg::frsd_sat(div_value);
  wire [12:0] dly_eff     = frsd_pkg::frsd_sat(dly_value);

  frsd_pkg::frsd_src_t src_mode;
  assign src_mode = frsd_pkg::frsd_src_t'(src_reg[1:0]);

  wire pulser_sel = (src_mode == frsd_pkg::FRSD_SRC_PULSER);

  // Burst state
  logic       burst_active;
  logic [3:0] pulses_left;

  // In other modes a count write only stores the value
  wire burst_start = wr_take && hit_burst && pulser_sel && !frame_pd && !pulser_pd;
  wire [3:0] burst_len = 4'(4'h1 << wdat[1:0]);

  // Divider runs only when powered, and in pulser mode only during a burst
  wire div_run = !frame_pd && (!pulser_sel || burst_active);

  logic div_clk;
  logic div_rise;
  logic div_fall;

  frsd_divider #(
    .W (13)
  ) u_divider (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .run     (div_run),
    .period  (div_eff),
    .delay   (dly_eff),
    .clk_out (div_clk),
    .rise    (div_rise),
    .fall    (div_fall)
  );

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      burst_active <= 1'b0;
      pulses_left  <= 4'h0;
    end else if (burst_start) begin
      burst_active <= 1'b1;
      pulses_left  <= burst_len;
    end else if (frame_pd || pulser_pd || !pulser_sel) begin
      burst_active <= 1'b0;
      pulses_left  <= 4'h0;
    end else if (burst_active && div_fall) begin
      pulses_left  <= 4'(pulses_left - 4'h1);
      burst_active <= (pulses_left != 4'h1);
    end
  end

  // Re-clocked sync sampled on divider rising edges
  logic sync_reclk;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sync_reclk <= 1'b0;
    end else if (frame_pd) begin
      sync_reclk <= 1'b0;
    end else if (div_rise) begin
      sync_reclk <= sync_s;
    end
  end

  // Source mux and bypass
  logic mux_out;

  always_comb begin
    unique case (src_mode)
      frsd_pkg::FRSD_SRC_NORMAL:  mux_out = sync_s;
      frsd_pkg::FRSD_SRC_RECLOCK: mux_out = sync_reclk;
      frsd_pkg::FRSD_SRC_PULSER:  mux_out = div_clk && burst_active && !pulser_pd;
      frsd_pkg::FRSD_SRC_CONT:    mux_out = div_clk;
    endcase
  end

  wire next_frame = frame_pd ? 1'b0 : (bypass ? first_s : mux_out);

  // Buffered output format decode
  wire cmos_mode = (out_code >= `FRSD_OUT_CMOS_FIRST) && (out_code <= `FRSD_OUT_CMOS_LAST);

  frsd_pkg::frsd_pin_t pin_a;
  frsd_pkg::frsd_pin_t pin_b;

  always_comb begin
    pin_a = frsd_pkg::FRSD_PIN_OFF;
    pin_b = frsd_pkg::FRSD_PIN_OFF;
    unique case (out_code)
      4'h6: begin
        pin_a = frsd_pkg::FRSD_PIN_NORM;
        pin_b = frsd_pkg::FRSD_PIN_INV;
      end
      4'h7: begin
        pin_a = frsd_pkg::FRSD_PIN_INV;
        pin_b = frsd_pkg::FRSD_PIN_NORM;
      end
      4'h8: begin
        pin_a = frsd_pkg::FRSD_PIN_NORM;
        pin_b = frsd_pkg::FRSD_PIN_NORM;
      end
      4'h9: begin
        pin_a = frsd_pkg::FRSD_PIN_INV;
        pin_b = frsd_pkg::FRSD_PIN_INV;
      end
      4'ha: begin
        pin_b = frsd_pkg::FRSD_PIN_NORM;
      end
      4'hb: begin
        pin_b = frsd_pkg::FRSD_PIN_INV;
      end
      4'hc: begin
        pin_a = frsd_pkg::FRSD_PIN_NORM;
      end
      4'hd: begin
        pin_a = frsd_pkg::FRSD_PIN_INV;
      end
      default: begin
        pin_a = frsd_pkg::FRSD_PIN_OFF;
        pin_b = frsd_pkg::FRSD_PIN_OFF;
      end
    endcase
  end

  wire next_a_oe = cmos_mode && (pin_a != frsd_pkg::FRSD_PIN_OFF);
  wire next_b_oe = cmos_mode && (pin_b != frsd_pkg::FRSD_PIN_OFF);
  wire next_a    = next_a_oe && (osc_s ^ (pin_a == frsd_pkg::FRSD_PIN_INV));
  wire next_b    = next_b_oe && (osc_s ^ (pin_b == frsd_pkg::FRSD_PIN_INV));

  // Output registers, reserved distribution codes select neither oscillator
  // CMOS pins follow the synced oscillator reference
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      DIST_FIRST_OSC     <= 1'b0;
      DIST_SECOND_OSC    <= 1'b0;
      BUF_OUT_LVDS       <= 1'b0;
      BUF_OUT_LVPECL     <= 1'b0;
      BUF_OUT_SWING_HIGH <= 1'b0;
      THIRD_REF_IN_EN    <= 1'b0;
      BUF_CMOS_A_O       <= 1'b0;
      BUF_CMOS_A_OE      <= 1'b0;
      BUF_CMOS_B_O       <= 1'b0;
      BUF_CMOS_B_OE      <= 1'b0;
      FRAME_REF_OUT      <= 1'b0;
    end else begin
      DIST_FIRST_OSC     <= (dist_code == `FRSD_DIST_FIRST);
      DIST_SECOND_OSC    <= (dist_code == `FRSD_DIST_SECOND);
      BUF_OUT_LVDS       <= (out_code == `FRSD_OUT_LVDS);
      BUF_OUT_LVPECL     <= (out_code == `FRSD_OUT_PECL_LO) || (out_code == `FRSD_OUT_PECL_HI);
      BUF_OUT_SWING_HIGH <= (out_code == `FRSD_OUT_PECL_HI);
      THIRD_REF_IN_EN    <= (out_code == `FRSD_OUT_OFF);
      BUF_CMOS_A_O       <= next_a;
      BUF_CMOS_A_OE      <= next_a_oe;
      BUF_CMOS_B_O       <= next_b;
      BUF_CMOS_B_OE      <= next_b_oe;
      FRAME_REF_OUT      <= next_frame;
    end
  end

  // Per-register write strobes
  wire wr_fmt    = wr_take && hit_fmt;
  wire wr_src    = wr_take && hit_src;
  wire wr_div_hi = wr_take && hit_div_hi;
  wire wr_div_lo = wr_take && hit_div_lo;
  wire wr_dly_hi = wr_take && hit_dly_hi;
  wire wr_dly_lo = wr_take && hit_dly_lo;
  wire wr_burst  = wr_take && hit_burst;
  wire wr_pd     = wr_take && hit_pd;

  // Register writes
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      fmt_reg   <= `FRSD_RST_FMT;
      src_reg   <= `FRSD_RST_SRC;
      div_hi    <= `FRSD_RST_DIV_HI;
      div_lo    <= `FRSD_RST_DIV_LO;
      dly_hi    <= `FRSD_RST_DLY_HI;
      dly_lo    <= `FRSD_RST_DLY_LO;
      burst_reg <= `FRSD_RST_BURST;
      pd_reg    <= `FRSD_RST_PD;
    end else begin
      if (wr_fmt) begin
        fmt_reg <= wdat & `FRSD_MSK_FMT;
      end
      if (wr_src) begin
        src_reg <= wdat & `FRSD_MSK_SRC;
      end
      if (wr_div_hi) begin
        div_hi <= wdat & `FRSD_MSK_HI;
      end
      if (wr_div_lo) begin
        div_lo <= wdat & `FRSD_MSK_LO;
      end
      if (wr_dly_hi) begin
        dly_hi <= wdat & `FRSD_MSK_HI;
      end
      if (wr_dly_lo) begin
        dly_lo <= wdat & `FRSD_MSK_LO;
      end
      if (wr_burst) begin
        burst_reg <= wdat & `FRSD_MSK_BURST;
      end
      if (wr_pd) begin
        pd_reg <= wdat & `FRSD_MSK_PD;
      end
    end
  end

  // Read mux, unmapped reads zero
  wire [7:0] status_byte = {3'h0, burst_active, pulses_left};
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_fmt)    rd_byte = fmt_reg;
    if (hit_src)    rd_byte = src_reg;
    if (hit_div_hi) rd_byte = div_hi;
    if (hit_div_lo) rd_byte = div_lo;
    if (hit_dly_hi) rd_byte = dly_hi;
    if (hit_dly_lo) rd_byte = dly_lo;
    if (hit_burst)  rd_byte = burst_reg;
    if (hit_pd)     rd_byte = pd_reg;
    if (hit_status) rd_byte = status_byte;
  end

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= ack_next;
      if (ack_next) begin
        WB_DAT_O <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule : frsd_regbank

// *** sim/frsd_regbank_checker.sv ***
`timescale 1ns/1ps
`include "frsd_defines.svh"

module frsd_regbank_checker (
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [15:0] WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        DIST_FIRST_OSC,
  input wire logic        DIST_SECOND_OSC,
  input wire logic        BUF_OUT_LVDS,
  input wire logic        BUF_OUT_LVPECL,
  input wire logic        BUF_OUT_SWING_HIGH,
  input wire logic        THIRD_REF_IN_EN,
  input wire logic        BUF_CMOS_A_O,
  input wire logic        BUF_CMOS_A_OE,
  input wire logic        FRAME_REF_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  // Accepted write to the format register
  wire fmt_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I[15:2] == `FRSD_IDX_FMT;
  // Accepted write to the powerdown register
  wire pd_wr  = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I[15:2] == `FRSD_IDX_PD;

  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  dist_excl_a: assert property (!(DIST_FIRST_OSC && DIST_SECOND_OSC))
    else $error("both oscillators selected");
  second_osc_a: assert property (fmt_wr && WB_DAT_I[6:5] == 2'h1 |-> ##[1:2] DIST_SECOND_OSC)
    else $error("second oscillator not selected");
  lvds_write_a: assert property (fmt_wr && WB_DAT_I[3:0] == 4'h1 |-> ##[1:2] BUF_OUT_LVDS)
    else $error("lvds not selected");
  third_ref_a: assert property (fmt_wr && WB_DAT_I[3:0] == 4'h0 |-> ##[1:2] THIRD_REF_IN_EN)
    else $error("third input not freed");
  fmt_excl_a: assert property (BUF_OUT_SWING_HIGH |-> BUF_OUT_LVPECL && !BUF_OUT_LVDS)
    else $error("format outputs conflict");
  cmos_fmt_a: assert property (BUF_CMOS_A_OE |-> !BUF_OUT_LVDS && !BUF_OUT_LVPECL && !THIRD_REF_IN_EN)
    else $error("cmos pin with other format");
  cmos_off_a: assert property (!BUF_CMOS_A_OE |-> !BUF_CMOS_A_O)
    else $error("cmos pin drives while off");
  frame_reset_a: assert property ($fell(SRST) |-> !FRAME_REF_OUT)
    else $error("frame output active after reset");
  frame_pd_a: assert property (pd_wr && WB_DAT_I[`FRSD_PD_FRAME] |-> ##2 !FRAME_REF_OUT)
    else $error("frame output live in powerdown");

  cover property (fmt_wr);
  cover property ($rose(FRAME_REF_OUT));
  cover property (BUF_CMOS_A_OE && BUF_CMOS_A_O);
endmodule : frsd_regbank_checker

bind frsd_regbank frsd_regbank_checker i_frsd_regbank_checker (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .DIST_FIRST_OSC(DIST_FIRST_OSC), .DIST_SECOND_OSC(DIST_SECOND_OSC), .BUF_OUT_LVDS(BUF_OUT_LVDS),
  .BUF_OUT_LVPECL(BUF_OUT_LVPECL), .BUF_OUT_SWING_HIGH(BUF_OUT_SWING_HIGH), .THIRD_REF_IN_EN(THIRD_REF_IN_EN),
  .BUF_CMOS_A_O(BUF_CMOS_A_O), .BUF_CMOS_A_OE(BUF_CMOS_A_OE), .FRAME_REF_OUT(FRAME_REF_OUT));

// *** sim/frsd_converter_model.sv ***
`timescale 1ns/1ps

// Converter side: drives reference pins, times frame-reference edges
module frsd_converter_model (
  input  wire logic clk,
  input  wire logic frame_ref,
  input  wire logic osc_lvl,
  input  wire logic sync_lvl,
  input  wire logic ref_lvl,
  output logic      osc_ref,
  output logic      sync_pin,
  output logic      first_ref,
  output int        pulses,
  output int        period,
  output int        high_len,
  output int        last_rise,
  output int        cyc_n
);
  logic prev = 1'b0;
  int   run;

  assign osc_ref = osc_lvl;
  assign sync_pin = sync_lvl;
  assign first_ref = ref_lvl;

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    prev <= frame_ref;
    run <= frame_ref ? run + 1 : 0;
    if (frame_ref && !prev) begin
      pulses <= pulses + 1;
      period <= cyc_n - last_rise;
      last_rise <= cyc_n;
    end
    if (!frame_ref && prev) begin
      high_len <= run;
    end
  end
endmodule : frsd_converter_model

// *** sim/frsd_regbank_tb_top.sv ***
`timescale 1ns/1ps
`include "frsd_defines.svh"

module frsd_regbank_tb_top;
  logic        clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        osc_lvl = 1'b1, sync_lvl = 1'b0, ref_lvl = 1'b0, ack, fro, osc, syn, fref;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000, dat_o, rdat;
  logic [9:0]  pins;
  logic [3:0]  sel = 4'h1, lanes = 4'h1;
  int          errors, checks, pulses, period, high_len, last_rise, cyc_n;
  logic [13:0] ix [9] = '{`FRSD_IDX_FMT, `FRSD_IDX_SRC, `FRSD_IDX_DIV_HI, `FRSD_IDX_DIV_LO, `FRSD_IDX_DLY_HI,
                          `FRSD_IDX_DLY_LO, `FRSD_IDX_BURST, `FRSD_IDX_PD, 14'h0180};
  logic [7:0]  rv [9] = '{8'h04, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h08, 8'h03, 8'h05, 8'h00};
  logic [1:0]  pa [6:14] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [1:0]  pb [6:14] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};

  always #4 clk = ~clk;

  frsd_regbank i_frsd_regbank (
    .CLK_SYS(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .OSC_REF_IN(osc),
    .FIRST_REF_IN(fref), .SYNC_IN(syn), .DIST_FIRST_OSC(pins[5]), .DIST_SECOND_OSC(pins[4]),
    .BUF_OUT_LVDS(pins[9]), .BUF_OUT_LVPECL(pins[8]), .BUF_OUT_SWING_HIGH(pins[7]),
    .THIRD_REF_IN_EN(pins[6]), .BUF_CMOS_A_O(pins[2]), .BUF_CMOS_A_OE(pins[3]),
    .BUF_CMOS_B_O(pins[0]), .BUF_CMOS_B_OE(pins[1]), .FRAME_REF_OUT(fro));

  frsd_converter_model i_frsd_converter_model (
    .clk(clk), .frame_ref(fro), .osc_lvl(osc_lvl), .sync_lvl(sync_lvl), .ref_lvl(ref_lvl),
    .osc_ref(osc), .sync_pin(syn), .first_ref(fref), .pulses(pulses), .period(period),
    .high_len(high_len), .last_rise(last_rise), .cyc_n(cyc_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel <= lanes;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic t_reset;
    check(pins, 10'h120);
    check(fro, 1'b0);
    wb(1'b1, ix[8], 8'hff);
    // Lane zero off: the write must be dropped
    lanes = 4'h0;
    wb(1'b1, `FRSD_IDX_FMT, 8'h01);
    lanes = 4'h1;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, ix[i], 8'h00);
      check(rdat, {24'h000000, rv[i]});
    end
  endtask : t_reset

  task automatic t_format;
    logic [1:0] d, a, b;
    for (int l = 1; l >= 0; l--) begin
      for (int c = 0; c < 15; c++) begin
        if (c == 2 || c == 3) continue;
        d = 2'(c % 2);
        a = (c >= 6) ? pa[c] : 2'h0;
        b = (c >= 6) ? pb[c] : 2'h0;
        osc_lvl <= l[0];
        wb(1'b1, `FRSD_IDX_FMT, {1'b0, d, 1'b0, 4'(c)});
        wt(6);
        check(pins, {c == 1, c == 4 || c == 5, c == 5, c == 0, d == 2'h0, d == 2'h1, a != 2'h0,
                     a == 2'(2 - l), b != 2'h0, b == 2'(2 - l)});
        wb(1'b0, `FRSD_IDX_FMT, 8'h00);
        check(rdat, {25'h0, d, 1'b0, 4'(c)});
      end
    end
  endtask : t_format

  task automatic measure(input logic [12:0] dv, input logic [12:0] dl, output int lat);
    int p0, t0;
    wb(1'b1, `FRSD_IDX_PD, 8'h04);
    wb(1'b1, `FRSD_IDX_SRC, 8'h03);
    wb(1'b1, `FRSD_IDX_DIV_HI, {3'h0, dv[12:8]});
    wb(1'b1, `FRSD_IDX_DIV_LO, dv[7:0]);
    wb(1'b1, `FRSD_IDX_DLY_HI, {3'h0, dl[12:8]});
    wb(1'b1, `FRSD_IDX_DLY_LO, dl[7:0]);
    p0 = pulses;
    wb(1'b1, `FRSD_IDX_PD, 8'h00);
    t0 = cyc_n;
    while (pulses == p0) @(posedge clk);
    lat = last_rise - t0;
    while (pulses < p0 + 3) @(posedge clk);
  endtask : measure

  task automatic t_divider;
    int l1, l2;
    measure(13'h0008, 13'h0008, l1);
    check(period, 8);
    check(high_len, 4);
    measure(13'h0109, 13'h0108, l2);
    check(period, 265);
    check(high_len, 133);
    check(l2 - l1, 256);
  endtask : t_divider

  task automatic t_burst;
    int p0;
    logic [7:0] pd [3] = '{8'h01, 8'h04, 8'h00};
    logic [7:0] sr [3] = '{8'h02, 8'h02, 8'h00};
    measure(13'h0008, 13'h0008, p0);
    wb(1'b1, `FRSD_IDX_SRC, 8'h02);
    for (int c = 0; c < 4; c++) begin
      p0 = pulses;
      wb(1'b1, `FRSD_IDX_BURST, 8'(c));
      wb(1'b0, `FRSD_IDX_STATUS, 8'h00);
      check(rdat, 32'h10 | (1 << c));
      wt(150);
      check(pulses - p0, 1 << c);
    end
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `FRSD_IDX_PD, pd[i]);
      wb(1'b1, `FRSD_IDX_SRC, sr[i]);
      p0 = pulses;
      wb(1'b1, `FRSD_IDX_BURST, 8'h03);
      wt(150);
      check(pulses - p0, 0);
    end
  endtask : t_burst

  task automatic t_modes;
    int p0;
    sync_lvl <= 1'b1;
    wb(1'b1, `FRSD_IDX_PD, 8'h04);
    wt(8);
    check(fro, 1'b0);
    wb(1'b1, `FRSD_IDX_PD, 8'h00);
    wt(8);
    check(fro, 1'b1);
    sync_lvl <= 1'b0;
    wt(8);
    check(fro, 1'b0);
    wb(1'b1, `FRSD_IDX_SRC, 8'h04);
    ref_lvl <= 1'b1;
    wt(8);
    check(fro, 1'b1);
    ref_lvl <= 1'b0;
    wt(8);
    check(fro, 1'b0);
    wb(1'b1, `FRSD_IDX_SRC, 8'h01);
    p0 = pulses;
    sync_lvl <= 1'b1;
    wt(40);
    check(pulses != p0, 1'b1);
  endtask : t_modes

  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    wt(12);
    srst <= 1'b0;
    wt(2);
    t_reset;
    t_format;
    t_divider;
    t_burst;
    t_modes;
    report_and_stop;
  end

  initial begin
    wt(40000);
    errors++;
    report_and_stop;
  end
endmodule : frsd_regbank_tb_top
